// ==== common/asrc_pkg.sv ====
package asrc_pkg;
   // -----------------------------------------------------------------
   // Memory geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;

   // -----------------------------------------------------------------
   // Timing: figures in ns, counts derived from the 5 ns clock
   // -----------------------------------------------------------------
   localparam int CLK_NS = 5;
   localparam int T_ACCESS_NS = 15;   // Read access, least time.
   localparam int T_CYCLE_NS = 15;    // Read cycle, least time.
   localparam int T_WPULSE_NS = 15;   // Write pulse, least width.
   localparam int T_WLQZ_NS = 10;     // Write low to float, least wait.
   localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_CYCLE_CYC = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WPULSE_CYC = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WLQZ_CYC = (T_WLQZ_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

   // Pin values after reset: deselected, strobes high, bus released.
   localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

   // Strobe group that goes out to the memory pins.
   typedef struct packed {
      logic select_low_active_n;
      logic select_high_active;
      logic write_n;
      logic output_enable_n;
      logic upper_half_enable_n;
      logic lower_half_enable_n;
   } asrc_ctl_t;

   localparam asrc_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR_PULSE, ST_DONE
   } asrc_state_t;
endpackage

// ==== core/asrc_ctrl.sv ====
// Behaviour
// - Read asserts output enable, write high.
// - Address held at least one read cycle.
// - Select-started read holds controls steady.
// - Write pulse keeps least width.
// - Wait float delay before driving bus.
// - Half enables follow the request, write high when reading.
module asrc_ctrl
   import asrc_pkg::*;
(
   input wire logic sys_clk,                     // System clock.
   input wire logic resetn,                      // Sync reset, active low.
   input wire logic req_valid,                   // Request strobe.
   input wire logic req_write,                   // 1 write, 0 read.
   input wire logic [ADDR_W-1:0] req_addr,       // Word address.
   input wire logic [DATA_W-1:0] req_wdata,      // Write data.
   input wire logic [1:0] req_half_n,            // {upper,lower}, low on.
   output logic req_ready,                       // Idle, takes request.
   output logic rsp_valid,                       // Done pulse.
   output logic [DATA_W-1:0] rsp_rdata,          // Read data.
   output logic [ADDR_W-1:0] mem_addr,           // Address pins.
   output asrc_ctl_t mem_ctl,                    // Strobe pins.
   output logic [DATA_W-1:0] mem_dq_out,         // Data pins, out.
   output logic [DATA_W-1:0] mem_dq_oe_n,        // Data enable, low drives.
   input wire logic [DATA_W-1:0] mem_dq_in       // Data pins, in.
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   asrc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
   logic req_ready_reg, req_ready_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   asrc_ctl_t ctl_reg, ctl_next;
   logic [DATA_W-1:0] dq_out_reg, dq_out_next;
   logic [DATA_W-1:0] oe_n_reg, oe_n_next;

   // Lane enables follow the half enables already on the pins, so a
   // request input that moves after the take cannot steer the bus.
   wire logic [DATA_W-1:0] lane_mask_n =
      {{HALF_W{ctl_reg.upper_half_enable_n}},
       {HALF_W{ctl_reg.lower_half_enable_n}}};
   wire logic [DATA_W-1:0] lane_keep = ~lane_mask_n;
   wire logic cnt_done = (cnt_reg == CNT_RST);
   wire logic take = req_valid && req_ready_reg;

   // -----------------------------------------------------------------
   // Pin input synchroniser
   // -----------------------------------------------------------------
   // The data pins are asynchronous to sys_clk, so two stages guard them.
   always_ff @(posedge sys_clk) begin
      dq_s1_reg <= mem_dq_in;
      dq_s2_reg <= dq_s1_reg;
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // Each access is one deselect-to-deselect cycle, so every read is a
   // chip-select started read and the address never moves mid-cycle.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      req_ready_next = req_ready_reg;
      rsp_valid_next = 1'b0;
      rdata_next = rdata_reg;
      addr_next = addr_reg;
      ctl_next = ctl_reg;
      dq_out_next = dq_out_reg;
      oe_n_next = oe_n_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (take) begin
               req_ready_next = 1'b0;
               addr_next = req_addr;
               ctl_next.select_low_active_n = 1'b0;
               ctl_next.select_high_active = 1'b1;
               ctl_next.upper_half_enable_n = req_half_n[1];
               ctl_next.lower_half_enable_n = req_half_n[0];
               if (req_write) begin
                  // Write strobe first; the bus stays released while the
                  // memory drivers turn off.
                  ctl_next.write_n = 1'b0;
                  ctl_next.output_enable_n = 1'b1;
                  dq_out_next = req_wdata;
                  cnt_next = CNT_W'(T_WLQZ_CYC - 1);
                  state_next = ST_WR_SETUP;
               end else begin
                  // Read: output enable low, write strobe kept high.
                  ctl_next.write_n = 1'b1;
                  ctl_next.output_enable_n = 1'b0;
                  // One extra cycle per synchroniser stage, so the word
                  // sampled has settled before the first stage saw it.
                  cnt_next = CNT_W'(T_ACCESS_CYC + 2);
                  state_next = ST_RD;
               end
            end
         end
         ST_RD: begin
            // Address and strobes stay frozen for the cycle.
            if (cnt_done) begin
               rdata_next = dq_s2_reg & lane_keep;
               ctl_next = CTL_IDLE;
               rsp_valid_next = 1'b1;
               state_next = ST_DONE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_WR_SETUP: begin
            if (cnt_done) begin
               // Only enabled lanes are driven; both off leaves it released.
               oe_n_next = lane_mask_n;
               cnt_next = CNT_W'(T_WPULSE_CYC - 1);
               state_next = ST_WR_PULSE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_WR_PULSE: begin
            // The pulse runs from strobe low for at least its width.
            if (cnt_done) begin
               ctl_next = CTL_IDLE;
               rsp_valid_next = 1'b1;
               state_next = ST_DONE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_DONE: begin
            // Data is held one cycle past the strobe rise for hold time.
            oe_n_next = {DATA_W{1'b1}};
            req_ready_next = 1'b1;
            state_next = ST_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= CNT_RST;
         req_ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rdata_reg <= DATA_RST;
         addr_reg <= ADDR_RST;
         ctl_reg <= CTL_IDLE;
         dq_out_reg <= DATA_RST;
         oe_n_reg <= {DATA_W{1'b1}};
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         req_ready_reg <= (state_reg == ST_IDLE && !take) ? 1'b1
                                                           : req_ready_next;
         rsp_valid_reg <= rsp_valid_next;
         rdata_reg <= rdata_next;
         addr_reg <= addr_next;
         ctl_reg <= ctl_next;
         dq_out_reg <= dq_out_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign req_ready = req_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_rdata = rdata_reg;
   assign mem_addr = addr_reg;
   assign mem_ctl = ctl_reg;
   assign mem_dq_out = dq_out_reg;
   assign mem_dq_oe_n = oe_n_reg;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_read_open;
      !mem_ctl.output_enable_n && !mem_ctl.select_low_active_n;
   endsequence

   AST_RD_WRITE_HIGH: assert property (
      s_read_open |-> mem_ctl.write_n)
      else $error("Write strobe low during read.");
   AST_NO_CONTENTION: assert property (
      !mem_ctl.output_enable_n |-> &mem_dq_oe_n)
      else $error("Bus driven while memory may drive.");
   AST_ADDR_STABLE: assert property (
      !mem_ctl.select_low_active_n && $past(!mem_ctl.select_low_active_n)
      |-> $stable(mem_addr))
      else $error("Address moved inside a cycle.");
   AST_WR_PULSE: assert property (
      $fell(mem_ctl.write_n) |-> !mem_ctl.write_n [*5])
      else $error("Write pulse too short.");
   AST_WLQZ: assert property (
      $fell(mem_ctl.write_n) |-> &mem_dq_oe_n [*2])
      else $error("Data driven before float delay.");
   AST_RD_ACCESS: assert property (
      $fell(mem_ctl.output_enable_n) |-> !mem_ctl.output_enable_n [*5])
      else $error("Read ended before access time.");
   AST_RD_DONE: assert property (
      $fell(mem_ctl.output_enable_n) |-> ##[5:6] rsp_valid)
      else $error("Read did not complete in time.");
   AST_HALF_HOLD: assert property (
      !mem_ctl.select_low_active_n && $past(!mem_ctl.select_low_active_n)
      |-> $stable(mem_ctl.upper_half_enable_n)
          && $stable(mem_ctl.lower_half_enable_n))
      else $error("Half enables moved inside a cycle.");
endmodule

// ==== sim/asrc_sram_model.sv ====
// Behavioural memory on the far side of the pins; it also counts
// controller timing faults so that the bench can judge them.
module asrc_sram_model
   import asrc_pkg::*;
(
   input wire logic [ADDR_W-1:0] mem_addr, // Address pins.
   input wire asrc_ctl_t mem_ctl, // Strobe pins.
   input wire logic [DATA_W-1:0] mem_dq_out, // Controller data.
   input wire logic [DATA_W-1:0] mem_dq_oe_n, // Controller enable, low drives.
   output logic [DATA_W-1:0] mem_dq_in, // Resolved bus level.
   output int proto_errs // Controller timing faults seen.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] q_word;
   logic [DATA_W-1:0] float_pat = 32'h5A5A5A5A;
   logic rd_ok;
   realtime t_wr = 0.0;
   realtime t_wl = -1.0e3;
   // Pin decode; a deselect or a write turns the drivers off at once.
   wire sel = !mem_ctl.select_low_active_n
      && mem_ctl.select_high_active;
   wire wr = sel && !mem_ctl.write_n;
   wire rd = sel && mem_ctl.write_n
      && !mem_ctl.output_enable_n;
   wire [DATA_W-1:0] lanes = {{HALF_W{!mem_ctl.upper_half_enable_n}},
      {HALF_W{!mem_ctl.lower_half_enable_n}}};
   wire [DATA_W-1:0] drv = (rd && rd_ok) ? lanes : 32'h00000000;
   // Inertial delays restart the access on every select, enable or
   // address change, so data shows only after the last of them.
   assign #(T_ACCESS_NS) q_word = mem[mem_addr];
   assign #(T_ACCESS_NS) rd_ok = rd;
   // Released lines toggle so that a stale value is never mistaken
   // for real data.
   always #(CLK_NS) float_pat = ~float_pat;
   assign mem_dq_in = (~mem_dq_oe_n & mem_dq_out) |
      (mem_dq_oe_n & drv & q_word) | (mem_dq_oe_n & ~drv & float_pat);
   initial proto_errs = 0;
   // Enabled lanes follow the bus while the write lasts.
   always @(mem_addr, mem_ctl, mem_dq_in) begin
      if (wr) begin
         mem[mem_addr] = (mem[mem_addr] & ~lanes)
            | (mem_dq_in & lanes);
      end
   end
   // Write pulse width and the float wait before the bus is driven.
   always @(wr) begin
      if (wr) begin
         t_wr = $realtime;
         t_wl = mem_ctl.output_enable_n ? -1.0e3 : $realtime;
      end else if (t_wr > 0.0 && $realtime - t_wr < T_WPULSE_NS) begin
         proto_errs++;
      end
   end
   always @(mem_dq_oe_n) begin
      if (wr && !(&mem_dq_oe_n) && $realtime - t_wl < T_WLQZ_NS) begin
         proto_errs++;
      end
   end
endmodule

// ==== sim/async_sram_32bit_halfword_tb.sv ====
module async_sram_32bit_halfword_tb
   import asrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [ADDR_W-1:0] req_addr = 17'h00000;
   logic [DATA_W-1:0] req_wdata = 32'h00000000;
   logic [1:0] req_half_n = 2'h3;
   logic req_ready, rsp_valid;
   logic [DATA_W-1:0] rsp_rdata, mem_dq_out, mem_dq_oe_n, mem_dq_in;
   logic [ADDR_W-1:0] mem_addr;
   asrc_ctl_t mem_ctl;
   int proto_errs, failures = 0, total_checks = 0, cycles = 0;

   asrc_ctrl asrc_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_half_n(req_half_n),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .mem_addr(mem_addr), .mem_ctl(mem_ctl), .mem_dq_out(mem_dq_out),
      .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in));
   asrc_sram_model asrc_sram_model_inst (.mem_addr(mem_addr),
      .mem_ctl(mem_ctl), .mem_dq_out(mem_dq_out),
      .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in),
      .proto_errs(proto_errs));

   always #2.5 sys_clk = ~sys_clk;

   // A hang ends the run through the same closing report.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         $display("[ERR] run_length expected 4000 seen %0d", cycles);
         end_sim;
      end
   end

   task automatic check(input string what, input logic [DATA_W-1:0] exp,
         input logic [DATA_W-1:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One access; pins are judged two edges after the take, and a read
   // is compared with the expected word when the response pulses.
   task automatic access(input logic w, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input logic [1:0] h,
         input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req_half_n <= h;
      do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 20);
      req_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("pins", {10'h000, a, 2'h1, !w, h}, {10'h000, mem_addr,
         mem_ctl.select_low_active_n, mem_ctl.select_high_active,
         mem_ctl.write_n, mem_ctl.upper_half_enable_n,
         mem_ctl.lower_half_enable_n});
      if (!w) check("read_oe_n", 32'h0,
         {31'h0, mem_ctl.output_enable_n});
      do @(posedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 40);
      check("rsp_wait", 32'h0, {31'h0, n >= 40});
      if (!w) check("rdata", exp, rsp_rdata);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      check("reset_ctl", {26'h0, CTL_IDLE}, {26'h0, mem_ctl});
      check("reset_oe_n", 32'hFFFFFFFF, mem_dq_oe_n);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      $display("test reset done");
      // Both ends of the address range, full words.
      access(1'b1, 17'h1FFFF, 32'h12345678, 2'h0, 32'h0);
      access(1'b1, 17'h00000, 32'hCAFEF00D, 2'h0, 32'h0);
      access(1'b0, 17'h1FFFF, 32'h0, 2'h0, 32'h12345678);
      access(1'b0, 17'h00000, 32'h0, 2'h0, 32'hCAFEF00D);
      $display("test full_word done");
      // Half-word lanes; unused lanes read back as zero.
      access(1'b1, 17'h00000, 32'hAAAABBBB, 2'h1, 32'h0);
      access(1'b0, 17'h00000, 32'h0, 2'h0, 32'hAAAAF00D);
      access(1'b0, 17'h00000, 32'h0, 2'h2, 32'h0000F00D);
      access(1'b0, 17'h00000, 32'h0, 2'h1, 32'hAAAA0000);
      $display("test half_word done");
      // Both lanes off: the stored word must survive a write.
      access(1'b1, 17'h00000, 32'hFFFFFFFF, 2'h3, 32'h0);
      access(1'b0, 17'h00000, 32'h0, 2'h3, 32'h00000000);
      access(1'b0, 17'h00000, 32'h0, 2'h0, 32'hAAAAF00D);
      $display("test lanes_off done");
      check("proto_errs", 32'h0, 32'(proto_errs));
      $display("test timing done");
      end_sim;
   end
endmodule
